/* sfp_defines.vh */
// Shared constants of the serial flash program and erase sequencer.
// Operation
// R1: Quad data program data bytes arrive four bits per clock on serial_io3..0.
// R2: Host sends opcode, three address bytes, data, all under low chip select.
// R3: Data past page end wraps to offset zero of the same page.
// R4: Over 256 data bytes: later bytes overwrite, final 256 get programmed.
// R5: Under 256 bytes: only addressed bytes programmed, rest of page untouched.
// R6: Chip select must rise on a byte boundary, else program is discarded.
// R7: Chip select rise starts timed cycle; busy flag high until it ends. The busy flag here reads low while a cycle is paused.
// R8: Write permit latch cleared before every program or erase completes.
// R9: Quad program to a block-protected page is not executed.
// R10: Running quad program pauses on pause command, resumes on continue command.
// R11: Quad full program also sends the address four bits per clock.
// R12: Modify commands need the write permit latch set by a prior permit command.
// R13: OTP program writes up to 64 bytes, bits only from 1 to 0.
// R14: OTP has no wrap; at most 65 bytes latched, extra bytes dropped.
// R15: Control byte 64 bit 0 at zero locks the 64 OTP bytes forever.
// R16: An OTP bit programmed to 0 never returns to 1.
// R17: OTP program during a running cycle is rejected, cycle unaffected.
// R18: 4 KB erase: opcode plus address, any address inside, sets all bits.
// R19: 4 KB erase must end right after last address byte, then timed cycle.
// R20: 4 KB erase in a hardware or software protected sector is not executed.
// R21: 4 KB erase during a running cycle is rejected, cycle unaffected.
// R22: 64 KB erase: same framing, refused if protected, can pause and resume.
// R23: Erase targets ignore address bits below the 4 KB or 64 KB boundary.
`ifndef SFP_DEFINES_VH
`define SFP_DEFINES_VH
`define SFP_CLK_MHZ       250
`define SFP_PROG_TIME_US  500
`define SFP_SUB_TIME_US   40000
`define SFP_SEC_TIME_US   600000
`define SFP_OP_QDP        8'h32
`define SFP_OP_QFP        8'h12
`define SFP_OP_OTP        8'h42
`define SFP_OP_SUB        8'h20
`define SFP_OP_SEC        8'hd8
`define SFP_OP_WP         8'h06
`define SFP_FIRST_ADDR    3'h1
`define SFP_FIRST_DATA    3'h4
`define SFP_DATA_SEEN     3'h5
`define SFP_OTP_BYTES     7'h41
`define SFP_OTP_LOCK_IDX  7'h40
`define SFP_OTP_LOCK_BIT  0
`define SFP_OTP_ERASED    8'hff
`define SFP_PAGE_LAST     8'hff
`define SFP_SUB_LSB       12
`define SFP_SEC_LSB       16
`define SFP_KIND_PROG     2'h0
`define SFP_KIND_OTP      2'h1
`define SFP_KIND_SUB      2'h2
`define SFP_KIND_SEC      2'h3
`endif

/* sfp_pin_sync.v */
// Three-stage pin synchroniser with agreement filter for the serial pins.
`timescale 1ns/1ps
module sfp_pin_sync #(
  parameter WIDTH = 6
) (
  input  wire             ref_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] pin_in,
  input  wire [WIDTH-1:0] pin_rst_val,
  output wire [WIDTH-1:0] pin_lvl
);
  reg [WIDTH-1:0] s1_ff;
  reg [WIDTH-1:0] s2_ff;
  reg [WIDTH-1:0] s3_ff;
  reg [WIDTH-1:0] lvl_ff;
  integer i;

  // The filtered level only moves when stages two and three agree, so a
  // metastable first stage never reaches the decode logic.
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s1_ff  <= pin_rst_val;
      s2_ff  <= pin_rst_val;
      s3_ff  <= pin_rst_val;
      lvl_ff <= pin_rst_val;
    end
    else
    begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (i = 0; i < WIDTH; i = i + 1)
      begin
        if (s2_ff[i] == s3_ff[i])
          lvl_ff[i] <= s3_ff[i];
      end
    end
  end

  assign pin_lvl = lvl_ff;
endmodule // sfp_pin_sync

/* sfp_otp_store.v */
// One-time-programmable area of 64 data bytes plus the lock control byte.
`timescale 1ns/1ps
`include "sfp_defines.vh"
module sfp_otp_store #(
  parameter BYTES = 65
) (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       wr_en,
  input  wire [6:0] wr_idx,
  input  wire [7:0] wr_data,
  input  wire [6:0] rd_idx,
  output reg  [7:0] rd_data,
  output wire       otp_locked
);
  reg [7:0] otp_mem [0:BYTES-1];
  integer i;

  wire lock_open = otp_mem[`SFP_OTP_LOCK_IDX][`SFP_OTP_LOCK_BIT];

  // Writes only clear bits; the control byte stays writable so that a lock can be set.
  // Power-on reset restores the erased image since this model has no retention.
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < BYTES; i = i + 1)
        otp_mem[i] <= `SFP_OTP_ERASED;
      rd_data <= `SFP_OTP_ERASED;
    end
    else
    begin
      if (wr_en && (wr_idx < `SFP_OTP_BYTES) && (wr_idx == `SFP_OTP_LOCK_IDX || lock_open)) // R15
        otp_mem[wr_idx] <= otp_mem[wr_idx] & wr_data; // R13 R16
      if (rd_idx < `SFP_OTP_BYTES)
        rd_data <= otp_mem[rd_idx];
      else
        rd_data <= `SFP_OTP_ERASED;
    end
  end

  assign otp_locked = ~lock_open;
endmodule // sfp_otp_store

/* sfp_program_erase.v */
// Command decode, page buffer and timed modify sequencer of the serial flash.
`timescale 1ns/1ps
`include "sfp_defines.vh"
module sfp_program_erase #(
  parameter SEC_W       = 7,
  parameter PROG_CYCLES = `SFP_PROG_TIME_US * `SFP_CLK_MHZ,
  parameter SUB_CYCLES  = `SFP_SUB_TIME_US * `SFP_CLK_MHZ,
  parameter SEC_CYCLES  = `SFP_SEC_TIME_US * `SFP_CLK_MHZ
) (
  input  wire                  ref_clk,
  input  wire                  rst_n,
  input  wire                  spi_cs_n,
  input  wire                  spi_clk,
  input  wire                  serial_io0,
  input  wire                  serial_io1,
  input  wire                  serial_io2,
  input  wire                  serial_io3,
  input  wire [3:0]            protect_size_bits,
  input  wire                  protect_from_bottom,
  input  wire [(1<<SEC_W)-1:0] soft_lock_bits,
  input  wire                  modify_pause_cmd,
  input  wire                  modify_continue_cmd,
  input  wire [6:0]            otp_rd_idx,
  output wire [7:0]            otp_rd_data,
  output wire                  otp_locked,
  output wire                  modify_busy_flag,
  output wire                  modify_paused,
  output wire                  write_permit_latch,
  output reg                   cmd_rejected,
  output reg                   mem_wr_en,
  output reg  [23:0]           mem_wr_addr,
  output reg  [7:0]            mem_wr_data,
  output reg                   mem_erase_en,
  output reg  [23:0]           mem_erase_addr,
  output reg                   mem_erase_64k
);
  localparam S_IDLE  = 3'b001;
  localparam S_WAIT  = 3'b010;
  localparam S_FLUSH = 3'b100;

  // Quad lanes apply to the address of the full variant and to data of both.
  function sfp_quad;
    input [2:0] nbytes;
    input [7:0] op;
    begin
      if (nbytes == 3'h0)
        sfp_quad = 1'b0;
      else if (nbytes < `SFP_FIRST_DATA)
        sfp_quad = (op == `SFP_OP_QFP); // R11
      else
        sfp_quad = (op == `SFP_OP_QFP) || (op == `SFP_OP_QDP); // R1
    end
  endfunction

  // Protected region grows by powers of two from the top, or the bottom.
  function sfp_bp_hit;
    input [SEC_W-1:0] sec;
    input [3:0]       bp;
    input             tb;
    reg   [SEC_W:0]   cnt;
    reg   [SEC_W:0]   full;
    begin
      full = {1'b1, {SEC_W{1'b0}}};
      if (bp > SEC_W)
        cnt = full;
      else
        cnt = {{SEC_W{1'b0}}, 1'b1} << (bp - 4'h1);
      if (bp == 4'h0)
        sfp_bp_hit = 1'b0;
      else if (tb)
        sfp_bp_hit = ({1'b0, sec} < cnt);
      else
        sfp_bp_hit = ({1'b0, sec} >= (full - cnt));
    end
  endfunction

  wire [5:0] pin_lvl;
  reg        cs_prev_ff;
  reg        clk_prev_ff;
  reg  [7:0] shift_ff;
  reg  [2:0] bit_ff;
  reg  [2:0] nbytes_ff;
  reg  [7:0] opcode_ff;
  reg  [23:0] addr_ff;
  reg  [7:0] ptr_ff;
  reg  [255:0] valid_ff;
  reg  [7:0] page_buf [0:255];
  reg  [2:0] st_ff;
  reg  [1:0] kind_ff;
  reg  [31:0] timer_ff;
  reg  [7:0] idx_ff;
  reg  [23:0] run_addr_ff;
  reg        paused_ff;
  reg        wel_ff;
  reg        otp_wr_en_ff;
  reg  [6:0] otp_wr_idx_ff;
  reg  [7:0] otp_wr_data_ff;

  sfp_pin_sync #(
    .WIDTH (6)
  ) u_sync (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .pin_in      ({spi_cs_n, spi_clk, serial_io3, serial_io2, serial_io1, serial_io0}),
    .pin_rst_val (6'h3f),
    .pin_lvl     (pin_lvl)
  );

  sfp_otp_store #(
    .BYTES (65)
  ) u_otp (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .wr_en      (otp_wr_en_ff),
    .wr_idx     (otp_wr_idx_ff),
    .wr_data    (otp_wr_data_ff),
    .rd_idx     (otp_rd_idx),
    .rd_data    (otp_rd_data),
    .otp_locked (otp_locked)
  );

  // Edges of the serial clock and chip select as seen on the filtered levels.
  wire       cs_n_l    = pin_lvl[5];
  wire       clk_rise  = pin_lvl[4] & ~clk_prev_ff & ~cs_n_l;
  wire       cs_rise   = cs_n_l & ~cs_prev_ff;
  wire       cs_fall   = ~cs_n_l & cs_prev_ff;
  wire       quad      = sfp_quad(nbytes_ff, opcode_ff);
  wire [3:0] nxt_bit   = {1'b0, bit_ff} + (quad ? 4'h4 : 4'h1);
  wire       byte_done = nxt_bit[3];
  wire [7:0] nxt_byte  = quad ? {shift_ff[3:0], pin_lvl[3:0]} : {shift_ff[6:0], pin_lvl[0]};
  wire       seq_idle  = st_ff[0];

  // Opcode classes.
  wire op_prog = (opcode_ff == `SFP_OP_QDP) || (opcode_ff == `SFP_OP_QFP);
  wire op_otp  = (opcode_ff == `SFP_OP_OTP);
  wire op_sub  = (opcode_ff == `SFP_OP_SUB);
  wire op_sec  = (opcode_ff == `SFP_OP_SEC);
  wire op_wp   = (opcode_ff == `SFP_OP_WP);
  wire op_mod  = op_prog | op_otp | op_sub | op_sec;

  // The buffer is frozen while a cycle runs so a stray frame cannot corrupt it.
  wire buf_take = clk_rise & ~cs_fall & byte_done & (nbytes_ff >= `SFP_FIRST_DATA) & seq_idle &
                  (op_prog | (op_otp & ({1'b0, ptr_ff} < {1'b0, `SFP_OTP_BYTES}))); // R14

  // Acceptance at chip select rise: whole bytes, permit held, no cycle running.
  wire [SEC_W-1:0] sec_idx = addr_ff[`SFP_SEC_LSB +: SEC_W];
  wire bp_hit   = sfp_bp_hit(sec_idx, protect_size_bits, protect_from_bottom);
  wire frame_ok = cs_rise & (bit_ff == 3'h0); // R6
  wire gate_ok  = frame_ok & wel_ff & seq_idle; // R12 R17 R21
  wire data_ok  = (nbytes_ff == `SFP_DATA_SEEN);
  wire addr_end = (nbytes_ff == `SFP_FIRST_DATA); // R19
  wire go_prog  = gate_ok & op_prog & data_ok & ~bp_hit; // R9
  wire go_otp   = gate_ok & op_otp & data_ok;
  wire go_sub   = gate_ok & op_sub & addr_end & ~bp_hit & ~soft_lock_bits[sec_idx]; // R20
  wire go_sec   = gate_ok & op_sec & addr_end & ~bp_hit & ~soft_lock_bits[sec_idx]; // R22
  wire launch   = go_prog | go_otp | go_sub | go_sec; // R7
  wire wp_ok    = frame_ok & op_wp & (nbytes_ff == `SFP_FIRST_ADDR);
  wire can_halt = (kind_ff != `SFP_KIND_OTP) & st_ff[1];
  wire flush_last = (kind_ff == `SFP_KIND_OTP) ? (idx_ff == {1'b0, `SFP_OTP_LOCK_IDX}) :
                    (idx_ff == `SFP_PAGE_LAST);

  // Frame decode: bit and byte counting, opcode, address and page pointer.
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cs_prev_ff  <= 1'b1;
      clk_prev_ff <= 1'b1;
      shift_ff    <= 8'h00;
      bit_ff      <= 3'h0;
      nbytes_ff   <= 3'h0;
      opcode_ff   <= 8'h00;
      addr_ff     <= 24'h000000;
      ptr_ff      <= 8'h00;
    end
    else
    begin
      cs_prev_ff  <= cs_n_l;
      clk_prev_ff <= pin_lvl[4];
      if (cs_fall)
      begin
        bit_ff    <= 3'h0;
        nbytes_ff <= 3'h0;
      end
      else if (clk_rise)
      begin
        bit_ff   <= nxt_bit[2:0];
        shift_ff <= nxt_byte;
        if (byte_done)
        begin
          if (nbytes_ff != `SFP_DATA_SEEN)
            nbytes_ff <= nbytes_ff + 3'h1;
          if (nbytes_ff == 3'h0)
            opcode_ff <= nxt_byte;
          else if (nbytes_ff < `SFP_FIRST_DATA)
          begin
            addr_ff <= {addr_ff[15:0], nxt_byte}; // R2
            ptr_ff  <= nxt_byte;
          end
          else if (buf_take)
            ptr_ff <= ptr_ff + 8'h01; // R3
        end
      end
    end
  end

  // Valid marks: cleared per frame, so untouched bytes are never written.
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      valid_ff <= {256{1'b0}};
    else if (cs_fall & seq_idle)
      valid_ff <= {256{1'b0}}; // R5
    else if (buf_take)
      valid_ff[ptr_ff] <= 1'b1;
  end

  // A later byte at the same offset simply overwrites the earlier one.
  always @(posedge ref_clk)
  begin
    if (buf_take)
      page_buf[ptr_ff] <= nxt_byte; // R4
  end

  // Write permit latch; launch cannot coincide with a permit frame.
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      wel_ff <= 1'b0;
    else if (launch)
      wel_ff <= 1'b0; // R8
    else if (wp_ok)
      wel_ff <= 1'b1;
  end

  // Modify sequencer: timed wait, then page or OTP flush, or an erase pulse.
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_ff          <= S_IDLE;
      kind_ff        <= `SFP_KIND_PROG;
      timer_ff       <= 32'h00000000;
      idx_ff         <= 8'h00;
      run_addr_ff    <= 24'h000000;
      paused_ff      <= 1'b0;
      cmd_rejected   <= 1'b0;
      mem_wr_en      <= 1'b0;
      mem_wr_addr    <= 24'h000000;
      mem_wr_data    <= 8'h00;
      mem_erase_en   <= 1'b0;
      mem_erase_addr <= 24'h000000;
      mem_erase_64k  <= 1'b0;
      otp_wr_en_ff   <= 1'b0;
      otp_wr_idx_ff  <= 7'h00;
      otp_wr_data_ff <= 8'h00;
    end
    else
    begin
      cmd_rejected <= cs_rise & op_mod & ~launch;
      mem_wr_en    <= 1'b0;
      mem_erase_en <= 1'b0;
      otp_wr_en_ff <= 1'b0;
      case (st_ff)
        S_IDLE:
        begin
          paused_ff <= 1'b0;
          if (launch)
          begin
            st_ff       <= S_WAIT;
            run_addr_ff <= addr_ff;
            idx_ff      <= 8'h00;
            if (go_prog)
            begin
              kind_ff  <= `SFP_KIND_PROG;
              timer_ff <= PROG_CYCLES;
            end
            else if (go_otp)
            begin
              kind_ff  <= `SFP_KIND_OTP;
              timer_ff <= PROG_CYCLES;
            end
            else if (go_sub)
            begin
              kind_ff  <= `SFP_KIND_SUB;
              timer_ff <= SUB_CYCLES;
            end
            else
            begin
              kind_ff  <= `SFP_KIND_SEC;
              timer_ff <= SEC_CYCLES;
            end
          end
        end
        S_WAIT:
        begin
          // Continue beats a simultaneous pause; OTP cycles cannot pause.
          if (modify_continue_cmd)
            paused_ff <= 1'b0; // R10
          else if (modify_pause_cmd & can_halt)
            paused_ff <= 1'b1; // R10 R22
          if (!paused_ff)
          begin
            if (timer_ff > 32'h00000001)
              timer_ff <= timer_ff - 32'h00000001;
            else if (kind_ff[1])
            begin
              st_ff          <= S_IDLE;
              mem_erase_en   <= 1'b1; // R18
              mem_erase_64k  <= (kind_ff == `SFP_KIND_SEC);
              if (kind_ff == `SFP_KIND_SEC)
                mem_erase_addr <= {run_addr_ff[23:`SFP_SEC_LSB], 16'h0000}; // R23
              else
                mem_erase_addr <= {run_addr_ff[23:`SFP_SUB_LSB], 12'h000}; // R23
            end
            else
              st_ff <= S_FLUSH;
          end
        end
        S_FLUSH:
        begin
          mem_wr_en      <= (kind_ff == `SFP_KIND_PROG) & valid_ff[idx_ff];
          mem_wr_addr    <= {run_addr_ff[23:8], idx_ff};
          mem_wr_data    <= page_buf[idx_ff];
          otp_wr_en_ff   <= (kind_ff == `SFP_KIND_OTP) & valid_ff[idx_ff]; // R13
          otp_wr_idx_ff  <= idx_ff[6:0];
          otp_wr_data_ff <= page_buf[idx_ff];
          idx_ff         <= idx_ff + 8'h01;
          if (flush_last)
            st_ff <= S_IDLE;
        end
        default:
          st_ff <= S_IDLE;
      endcase
    end
  end

  // Busy reads low while a cycle is paused so software can tell it stopped.
  assign modify_busy_flag   = ~st_ff[0] & ~paused_ff; // R7
  assign modify_paused      = paused_ff;
  assign write_permit_latch = wel_ff;
endmodule // sfp_program_erase

/* sfp_program_erase_properties.sv */
// Concurrent checks on the ports of the program and erase sequencer.
`timescale 1ns/1ps
module sfp_program_erase_properties #(
  parameter SEC_W = 7
) (
  input logic                  ref_clk,
  input logic                  rst_n,
  input logic [3:0]            protect_size_bits,
  input logic                  protect_from_bottom,
  input logic [(1<<SEC_W)-1:0] soft_lock_bits,
  input logic                  modify_pause_cmd,
  input logic                  modify_continue_cmd,
  input logic                  modify_busy_flag,
  input logic                  modify_paused,
  input logic                  write_permit_latch,
  input logic                  cmd_rejected,
  input logic                  mem_wr_en,
  input logic [23:0]           mem_wr_addr,
  input logic                  mem_erase_en,
  input logic [23:0]           mem_erase_addr,
  input logic                  mem_erase_64k
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Sector s lies in the span that the block-protect setting covers.
  function automatic logic prot(input int s, input logic [3:0] bp, input logic tb);
    int n;
    n = bp == 4'h0 ? 0 : bp > 4'h7 ? 1 << SEC_W : 1 << (bp - 4'h1);
    return tb ? s < n : s >= (1 << SEC_W) - n;
  endfunction

  // Memory strobes land only where protection allows, and erases only at aligned bases.
  prog_guard_a: assert property (
    mem_wr_en |-> !prot(mem_wr_addr[16+:SEC_W], protect_size_bits, protect_from_bottom))
    else $error("program write hit a protected sector");
  wipe_guard_a: assert property (
    mem_erase_en |-> !prot(mem_erase_addr[16+:SEC_W], protect_size_bits, protect_from_bottom)
    && !soft_lock_bits[mem_erase_addr[16+:SEC_W]]) else $error("erase hit a locked sector");
  wipe_align_a: assert property (
    mem_erase_en |-> (mem_erase_64k ? mem_erase_addr[15:0] == 16'h0
                                    : mem_erase_addr[11:0] == 12'h0))
    else $error("erase base not aligned");
  // A finished cycle has spent its permit; a launched one stands for a while.
  permit_spent_a: assert property (
    $fell(modify_busy_flag) && !modify_paused |-> !write_permit_latch)
    else $error("permit latch still set after a cycle");
  busy_holds_a: assert property (
    $rose(modify_busy_flag) && !$past(modify_paused) |-> (modify_busy_flag || modify_paused) [*8])
    else $error("busy flag too short");
  refuse_quiet_a: assert property (
    cmd_rejected && !modify_busy_flag && !modify_paused |=> !modify_busy_flag)
    else $error("refused frame launched a cycle");
  // Pause and resume follow only their own commands.
  pause_cause_a: assert property (
    $rose(modify_paused) |-> $past(modify_pause_cmd) || $past(modify_pause_cmd, 2))
    else $error("pause without command");
  resume_cause_a: assert property (
    $fell(modify_paused) |-> modify_busy_flag
    && ($past(modify_continue_cmd) || $past(modify_continue_cmd, 2)))
    else $error("resume without command");
endmodule // sfp_program_erase_properties

bind sfp_program_erase sfp_program_erase_properties #(.SEC_W(SEC_W))
  i_sfp_program_erase_properties (
  .ref_clk(ref_clk), .rst_n(rst_n), .protect_size_bits(protect_size_bits),
  .protect_from_bottom(protect_from_bottom), .soft_lock_bits(soft_lock_bits),
  .modify_pause_cmd(modify_pause_cmd), .modify_continue_cmd(modify_continue_cmd),
  .modify_busy_flag(modify_busy_flag), .modify_paused(modify_paused),
  .write_permit_latch(write_permit_latch), .cmd_rejected(cmd_rejected),
  .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_erase_en(mem_erase_en),
  .mem_erase_addr(mem_erase_addr), .mem_erase_64k(mem_erase_64k));

/* sfp_host_model.sv */
// Host controller model that clocks command frames into the flash.
`timescale 1ns/1ps
module sfp_host_model (
  output logic spi_cs_n,
  output logic spi_clk,
  output logic serial_io0,
  output logic serial_io1,
  output logic serial_io2,
  output logic serial_io3
);
  localparam int HALF_NS = 24;
  logic [7:0] dat [0:299];
  logic [3:0] io_ff = 4'h0;

  // Lane 3 carries the high bit of each nibble.
  assign {serial_io3, serial_io2, serial_io1, serial_io0} = io_ff;

  // The link clock stands still low and chip select stays high between frames.
  initial
  begin
    spi_cs_n = 1'b1;
    spi_clk = 1'b0;
  end

  // Shifts nbits of b MSB first; idle lanes toggle so no stale level can be read.
  task automatic put(input logic [7:0] b, input int nbits, input bit quad);
    for (int i = 0; i < nbits; i += quad ? 4 : 1)
    begin
      if (quad)
        io_ff = b[7-i -: 4];
      else
        io_ff = {~io_ff[3:1], b[7-i]};
      #HALF_NS spi_clk = 1'b1;
      #HALF_NS spi_clk = 1'b0;
    end
  endtask

  // One frame under low chip select: opcode, address, data, then optional stray bits.
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int na,
                       input bit qa, input int nd, input bit qd, input int ex);
    spi_cs_n = 1'b0;
    #HALF_NS put(op, 8, 1'b0);
    for (int k = 0; k < na; k++)
      put(a[23-8*k -: 8], 8, qa);
    for (int k = 0; k < nd; k++)
      put(dat[k], 8, qd);
    if (ex > 0)
      put(8'ha5, ex, qd);
    #HALF_NS spi_cs_n = 1'b1;
    io_ff = ~io_ff;
    #(4*HALF_NS);
  endtask
endmodule // sfp_host_model

/* sfp_program_erase_bench.sv */
// Self-checking bench of the serial flash program and erase sequencer.
`timescale 1ns/1ps
`include "sfp_defines.vh"
module sfp_program_erase_bench;
  localparam int LIMIT = 40000;
  logic         ref_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         protect_from_bottom = 1'b0;
  logic         modify_pause_cmd = 1'b0;
  logic         modify_continue_cmd = 1'b0;
  logic [3:0]   protect_size_bits = 4'h0;
  logic [127:0] soft_lock_bits = 128'h0;
  logic [6:0]   otp_rd_idx = 7'h0;
  wire          spi_cs_n, spi_clk, serial_io0, serial_io1, serial_io2, serial_io3;
  wire          otp_locked, modify_busy_flag, modify_paused, write_permit_latch;
  wire          cmd_rejected, mem_wr_en, mem_erase_en, mem_erase_64k;
  wire  [7:0]   otp_rd_data, mem_wr_data;
  wire  [23:0]  mem_wr_addr, mem_erase_addr;
  int           n_fail, n_tests, cycles, wr_cnt, er_cnt, rej_cnt, rise_cnt;
  logic [7:0]   img [0:255];
  logic [15:0]  wr_hi;
  logic [23:0]  er_addr;
  logic         er_64k, busy_q, sec;
  logic [7:0]   e_op [0:4] = '{`SFP_OP_SUB, `SFP_OP_SEC, `SFP_OP_SUB, `SFP_OP_SEC, `SFP_OP_SUB};
  logic [23:0]  e_adr [0:4] = '{24'h012345, 24'h034567, 24'h05abcd, 24'h7f1234, 24'h001000};

  sfp_host_model i_sfp_host_model (.spi_cs_n(spi_cs_n), .spi_clk(spi_clk),
    .serial_io0(serial_io0), .serial_io1(serial_io1), .serial_io2(serial_io2),
    .serial_io3(serial_io3));

  sfp_program_erase #(.PROG_CYCLES(20), .SUB_CYCLES(20), .SEC_CYCLES(4000))
  i_sfp_program_erase (.ref_clk(ref_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n),
    .spi_clk(spi_clk), .serial_io0(serial_io0), .serial_io1(serial_io1),
    .serial_io2(serial_io2), .serial_io3(serial_io3), .protect_size_bits(protect_size_bits),
    .protect_from_bottom(protect_from_bottom), .soft_lock_bits(soft_lock_bits),
    .modify_pause_cmd(modify_pause_cmd), .modify_continue_cmd(modify_continue_cmd),
    .otp_rd_idx(otp_rd_idx), .otp_rd_data(otp_rd_data), .otp_locked(otp_locked),
    .modify_busy_flag(modify_busy_flag), .modify_paused(modify_paused),
    .write_permit_latch(write_permit_latch), .cmd_rejected(cmd_rejected),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .mem_erase_en(mem_erase_en), .mem_erase_addr(mem_erase_addr),
    .mem_erase_64k(mem_erase_64k));

  // 250 MHz clock.
  always #2 ref_clk = ~ref_clk;

  // Logs strobes, refusals and launches, and cuts a hung run short.
  always @(posedge ref_clk)
  begin
    cycles++;
    busy_q <= modify_busy_flag;
    if (modify_busy_flag === 1'b1 && busy_q === 1'b0)
      rise_cnt++;
    if (cmd_rejected === 1'b1)
      rej_cnt++;
    if (mem_wr_en === 1'b1)
    begin
      wr_cnt++;
      img[mem_wr_addr[7:0]] = mem_wr_data;
      wr_hi = mem_wr_addr[23:8];
    end
    if (mem_erase_en === 1'b1)
    begin
      er_cnt++;
      {er_64k, er_addr} = {mem_erase_64k, mem_erase_addr};
    end
    if (cycles == LIMIT)
    begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Sends one frame, then waits within a bound until the sequencer is idle.
  task automatic run(input logic [7:0] op, input logic [23:0] a, input int na, input bit qa,
                     input int nd, input bit qd, input int ex);
    {wr_cnt, er_cnt, rej_cnt, rise_cnt} = '0;
    i_sfp_host_model.frame(op, a, na, qa, nd, qd, ex);
    repeat (12) @(posedge ref_clk);
    for (int k = 0; k < 6000 && (modify_busy_flag !== 1'b0 || modify_paused !== 1'b0); k++)
      @(posedge ref_clk);
    #1;
  endtask

  task automatic permit;
    run(`SFP_OP_WP, 24'h0, 0, 0, 0, 0, 0);
    check("permit latch", write_permit_latch, 1'b1);
  endtask

  // The read port answers one cycle after the index is presented.
  task automatic otp_is(input logic [6:0] idx, input logic [7:0] exp);
    otp_rd_idx = idx;
    repeat (2) @(posedge ref_clk);
    #1 check("otp byte", otp_rd_data, exp);
  endtask

  // Main sequence after four reset cycles.
  initial
  begin
    repeat (4) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 i_sfp_host_model.dat[0:2] = '{8'h11, 8'h22, 8'h33};
    run(`SFP_OP_QDP, 24'h000100, 3, 0, 1, 1, 0);
    check("unpermitted", {rej_cnt[3:0], wr_cnt[3:0]}, 8'h10);
    permit();
    run(`SFP_OP_QDP, 24'h0123fe, 3, 0, 3, 1, 0);
    check("launches", rise_cnt, 1);
    check("latch spent", write_permit_latch, 1'b0);
    check("short writes", wr_cnt, 3);
    check("wrap", {img[8'hfe], img[8'hff], img[8'h00], wr_hi}, 40'h1122330123);
    for (int k = 0; k < 256; k++)
      i_sfp_host_model.dat[k] = 8'(k);
    i_sfp_host_model.dat[256:257] = '{8'hc3, 8'h3c};
    permit();
    run(`SFP_OP_QFP, 24'h020000, 3, 1, 258, 1, 0);
    check("long writes", wr_cnt, 256);
    check("last 256", {img[0], img[1], img[2], img[255], wr_hi}, 48'hc33c02ff0200);
    permit();
    run(`SFP_OP_QDP, 24'h0, 3, 0, 1, 1, 4);
    check("misframed", {rej_cnt[3:0], wr_cnt[3:0], 3'h0, write_permit_latch}, 9'h101);
    protect_size_bits = 4'h1;
    protect_from_bottom = 1'b1;
    run(`SFP_OP_QDP, 24'h000010, 3, 0, 1, 1, 0);
    check("protected page", {rej_cnt[3:0], wr_cnt[3:0]}, 8'h10);
    protect_from_bottom = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      soft_lock_bits = (i == 2) ? 128'h20 : 128'h0;
      protect_size_bits = (i == 3) ? 4'h1 : 4'h0;
      sec = e_op[i] == `SFP_OP_SEC;
      permit();
      run(e_op[i], e_adr[i], 3, 0, 0, 0, (i == 4) ? 8 : 0);
      check("erases", {er_cnt[3:0], rej_cnt[3:0]}, (i < 2) ? 8'h10 : 8'h01);
      if (i < 2)
        check("erase base", {er_64k, er_addr}, {sec, e_adr[i] & {8'hff, sec ? 16'h0 : 16'hf000}});
    end
    protect_size_bits = 4'h0;
    permit();
    fork
      run(`SFP_OP_SEC, 24'h100000, 3, 0, 0, 0, 0);
      begin
        wait (modify_busy_flag === 1'b1);
        i_sfp_host_model.frame(`SFP_OP_OTP, 24'h0, 3, 0, 1, 0, 0);
        i_sfp_host_model.frame(`SFP_OP_SUB, 24'h200000, 3, 0, 0, 0, 0);
        @(posedge ref_clk);
        #1 modify_pause_cmd = 1'b1;
        @(posedge ref_clk);
        #1 modify_pause_cmd = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1 check("paused", {modify_paused, modify_busy_flag}, 2'b10);
        modify_continue_cmd = 1'b1;
        @(posedge ref_clk);
        #1 modify_continue_cmd = 1'b0;
      end
    join
    check("cycle kept", {er_cnt[3:0], rise_cnt[3:0], rej_cnt[3:0], er_addr}, 36'h122100000);
    otp_is(7'h0, 8'hff);
    i_sfp_host_model.dat[0:2] = '{8'h0f, 8'h5a, 8'hfe};
    permit();
    run(`SFP_OP_OTP, 24'h0, 3, 0, 1, 0, 0);
    otp_is(7'h0, 8'h0f);
    i_sfp_host_model.dat[0] = 8'hf0;
    permit();
    run(`SFP_OP_OTP, 24'h0, 3, 0, 1, 0, 0);
    otp_is(7'h0, 8'h00);
    i_sfp_host_model.dat[0:2] = '{8'h5a, 8'hfe, 8'h00};
    permit();
    run(`SFP_OP_OTP, 24'h00003f, 3, 0, 3, 0, 0);
    otp_is(7'h3f, 8'h5a);
    check("otp locked", otp_locked, 1'b1);
    permit();
    run(`SFP_OP_OTP, 24'h000001, 3, 0, 1, 0, 0);
    otp_is(7'h1, 8'hff);
    print_verdict();
  end
endmodule // sfp_program_erase_bench
